// >>> design/dta_pkg.sv
// Package: constants, enumerations and carriers of the turnaround, acknowledge and interrupt block
package dta_pkg;

    // ------------------------------------------------------------
    // Link event codes seen on the receive event pins
    // ------------------------------------------------------------
    localparam int EVT_W = 3;
    typedef enum logic [2:0] {
        EVT_NONE       = 3'b000,
        EVT_BUS_RETURN = 3'b001,
        EVT_ACK_TRIG   = 3'b010,
        EVT_ERR_REPORT = 3'b011,
        EVT_READ_RESP  = 3'b100,
        EVT_TE_TRIG    = 3'b101,
        EVT_CONTENTION = 3'b110
    } dta_evt_t;

    // ------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_TX_IDLE = 2'b00,
        ST_BTA     = 2'b01,
        ST_PERIPH  = 2'b10,
        ST_TE_WAIT = 2'b11
    } dta_state_t;

    // ------------------------------------------------------------
    // Widths, reset values and error report layout
    // ------------------------------------------------------------
    localparam int ERR_W = 16;
    localparam int IRQ_W = 16;
    localparam int CNT_W = 16;
    localparam logic [ERR_W-1:0] ERR_REPORT_RST = 16'h0000;
    localparam int ERR_SOT = 0;
    localparam int ERR_SOT_SYNC = 1;
    localparam int ERR_EOT_SYNC = 2;
    localparam int ERR_ESC_ENTRY = 3;
    localparam int ERR_LP_TX_SYNC = 4;
    localparam int ERR_PERIPH_TIMEOUT = 5;
    localparam int ERR_FALSE_CTRL = 6;
    localparam int ERR_CONTENTION = 7;
    localparam int ERR_ECC_SINGLE = 8;
    localparam int ERR_ECC_MULTI = 9;
    localparam int ERR_CHECKSUM = 10;
    localparam int ERR_DT_UNKNOWN = 11;
    localparam int ERR_VC_INVALID = 12;
    localparam int ERR_LENGTH = 13;
    localparam int ERR_RESERVED = 14;
    localparam int ERR_PROTOCOL = 15;
    localparam logic [ERR_W-1:0] ERR_VALID_MASK = 16'hBFFF;

    // ------------------------------------------------------------
    // Interrupt status bit positions
    // ------------------------------------------------------------
    localparam int IRQ_READ_READY = 0;
    localparam int IRQ_BUS_RETURNED = 1;
    localparam int IRQ_ACK_RESP = 2;
    localparam int IRQ_PLL_LOCK = 3;
    localparam int IRQ_LP_TIMEOUT = 4;
    localparam int IRQ_HS_TIMEOUT = 5;
    localparam int IRQ_PKT_ACCEPT = 6;
    localparam int IRQ_BUF_BASE = 7;
    localparam int BUF_FLAG_N = 6;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 16'h0008;

    // ------------------------------------------------------------
    // Timer defaults in reference clock cycles
    // ------------------------------------------------------------
    localparam int LP_RX_TIMEOUT_CYC = 1024;
    localparam int HS_TX_TIMEOUT_CYC = 1024;

    // Sampled receive event with its payload
    typedef struct packed {
        dta_evt_t evt;
        logic [ERR_W-1:0] data;
    } dta_rx_t;

endpackage

// >>> design/dta_top.sv
// Turnaround, acknowledge, tearing-effect and interrupt logic of the serial link master
`timescale 1ns/1ps

module dta_top #(
    parameter int LP_RX_TIMEOUT = dta_pkg::LP_RX_TIMEOUT_CYC,
    parameter int HS_TX_TIMEOUT = dta_pkg::HS_TX_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Link receive pins, asynchronous to CLK_IN
    input wire logic LINK_CLK_IN,
    input wire logic [dta_pkg::EVT_W-1:0] RX_EVT_IN,
    input wire logic [dta_pkg::ERR_W-1:0] RX_DATA_IN,
    input wire logic PLL_LOCK_IN,
    // Packet engine handshake, same clock
    input wire logic PKT_SENT_IN,
    input wire logic PKT_IS_READ_IN,
    input wire logic OP_START_IN,
    input wire logic READ_ALL_DONE_IN,
    input wire logic HS_ACTIVE_IN,
    input wire logic [dta_pkg::BUF_FLAG_N-1:0] BUF_FLAGS_IN,
    input wire logic [dta_pkg::CNT_W-1:0] BUF_FREE_IN,
    // Host control bits
    input wire logic BTA_AFTER_WRITE_FLAG_IN,
    input wire logic REPEAT_TURNAROUND_FLAG_IN,
    input wire logic FORCE_CONTENTION_FLAG_IN,
    input wire logic TEARING_CLEAR_IN,
    input wire logic [dta_pkg::CNT_W-1:0] TEARING_PULSE_LENGTH_IN,
    input wire logic [dta_pkg::CNT_W-1:0] TOTAL_PAYLOAD_COUNT_IN,
    input wire logic [dta_pkg::CNT_W-1:0] PARTITION_SIZE_IN,
    input wire logic DCS_SEL_IN,
    input wire logic IRQ_ENABLE_WR_IN,
    input wire logic [dta_pkg::IRQ_W-1:0] IRQ_ENABLE_IN,
    // Link control outputs
    output logic BTA_REQ_OUT,
    output logic FORCE_CONTENTION_OUT,
    output logic LANE_LP11_OUT,
    output logic [1:0] LINK_STATE_OUT,
    output logic FRAME_SYNC_OUT,
    // Status outputs
    output logic BUS_RETURNED_FLAG_OUT,
    output logic ACK_RESPONSE_RECEIVED_OUT,
    output logic ACK_TRIGGER_NO_ERROR_OUT,
    output logic [dta_pkg::ERR_W-1:0] ACK_ERROR_REPORT_REG_OUT,
    output logic TEARING_EVENT_FLAG_OUT,
    output logic READ_DATA_READY_OUT,
    output logic [dta_pkg::IRQ_W-1:0] IRQ_STATUS_REG_OUT,
    output logic [dta_pkg::IRQ_W-1:0] IRQ_ENABLE_REG_OUT,
    output logic INT_N_OUT
);

    localparam logic [dta_pkg::CNT_W-1:0] LP_LIMIT = dta_pkg::CNT_W'(LP_RX_TIMEOUT);
    localparam logic [dta_pkg::CNT_W-1:0] HS_LIMIT = dta_pkg::CNT_W'(HS_TX_TIMEOUT);

    // Length of the next packet's payload as the buffers will see it
    function automatic logic [dta_pkg::CNT_W-1:0] next_pkt_len(
        input logic [dta_pkg::CNT_W-1:0] total_payload_count,
        input logic [dta_pkg::CNT_W-1:0] partition_size,
        input logic dcs
    );
        logic [dta_pkg::CNT_W-1:0] len;
        len = total_payload_count;
        if (partition_size != 16'h0000 && total_payload_count > partition_size) begin
            len = partition_size;
        end
        if (dcs) begin
            len = len + 16'h0001;
        end
        return len;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and link clock edge detect
    // ------------------------------------------------------------
    logic lclk_s1, lclk_s2, lclk_s3;
    dta_pkg::dta_rx_t rx_s1, rx_s2, rx_cap;
    logic pll_s1, pll_s2;
    logic rx_valid;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lclk_s1 <= 1'b0;
            lclk_s2 <= 1'b0;
            lclk_s3 <= 1'b0;
            rx_s1 <= '0;
            rx_s2 <= '0;
            pll_s1 <= 1'b0;
            pll_s2 <= 1'b0;
        end else begin
            lclk_s1 <= LINK_CLK_IN;
            lclk_s2 <= lclk_s1;
            lclk_s3 <= lclk_s2;
            rx_s1 <= {dta_pkg::dta_evt_t'(RX_EVT_IN), RX_DATA_IN};
            rx_s2 <= rx_s1;
            pll_s1 <= PLL_LOCK_IN;
            pll_s2 <= pll_s1;
        end
    end

    // Event pins are taken on the rising link clock edge, one pulse per event
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rx_cap <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= lclk_s2 && !lclk_s3;
            if (lclk_s2 && !lclk_s3) begin
                rx_cap <= rx_s2;
            end
        end
    end

    logic ev_bus_ret, ev_ack, ev_err, ev_resp, ev_te, ev_cont;
    assign ev_bus_ret = rx_valid && rx_cap.evt == dta_pkg::EVT_BUS_RETURN;
    assign ev_ack = rx_valid && rx_cap.evt == dta_pkg::EVT_ACK_TRIG;
    assign ev_err = rx_valid && rx_cap.evt == dta_pkg::EVT_ERR_REPORT;
    assign ev_resp = rx_valid && rx_cap.evt == dta_pkg::EVT_READ_RESP;
    assign ev_te = rx_valid && rx_cap.evt == dta_pkg::EVT_TE_TRIG;
    assign ev_cont = rx_valid && rx_cap.evt == dta_pkg::EVT_CONTENTION;

    // ------------------------------------------------------------
    // Link state machine
    // ------------------------------------------------------------
    dta_pkg::dta_state_t state;
    logic te_next;
    logic te_seen;
    logic lp_expired;
    logic [dta_pkg::CNT_W-1:0] lp_cnt;
    logic periph_owns;
    assign periph_owns = state == dta_pkg::ST_PERIPH || state == dta_pkg::ST_TE_WAIT;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state <= dta_pkg::ST_TX_IDLE;
            te_next <= 1'b0;
            te_seen <= 1'b0;
            BTA_REQ_OUT <= 1'b0;
            FORCE_CONTENTION_OUT <= 1'b0;
            LANE_LP11_OUT <= 1'b1;
            BUS_RETURNED_FLAG_OUT <= 1'b1;
        end else begin
            BTA_REQ_OUT <= 1'b0;
            FORCE_CONTENTION_OUT <= 1'b0;
            if (ev_cont) begin
                state <= dta_pkg::ST_TX_IDLE;
                LANE_LP11_OUT <= 1'b1;
                te_next <= 1'b0;
                BUS_RETURNED_FLAG_OUT <= 1'b1;
            end else begin
                case (state)
                    dta_pkg::ST_TX_IDLE: begin
                        LANE_LP11_OUT <= 1'b1;
                        if (PKT_SENT_IN && (PKT_IS_READ_IN || BTA_AFTER_WRITE_FLAG_IN)) begin
                            state <= dta_pkg::ST_BTA;
                            // Tearing mode only follows a write's turnaround
                            te_next <= !PKT_IS_READ_IN && REPEAT_TURNAROUND_FLAG_IN;
                            te_seen <= 1'b0;
                        end
                    end
                    dta_pkg::ST_BTA: begin
                        BTA_REQ_OUT <= 1'b1;
                        LANE_LP11_OUT <= 1'b0;
                        BUS_RETURNED_FLAG_OUT <= 1'b0;
                        state <= dta_pkg::ST_PERIPH;
                    end
                    dta_pkg::ST_PERIPH: begin
                        if (FORCE_CONTENTION_FLAG_IN) begin
                            FORCE_CONTENTION_OUT <= 1'b1;
                        end
                        if (lp_expired) begin
                            state <= dta_pkg::ST_TX_IDLE;
                            BUS_RETURNED_FLAG_OUT <= 1'b1;
                        end else if (ev_bus_ret) begin
                            BUS_RETURNED_FLAG_OUT <= 1'b1;
                            if (te_next && REPEAT_TURNAROUND_FLAG_IN) begin
                                state <= dta_pkg::ST_TE_WAIT;
                                BTA_REQ_OUT <= 1'b1;
                                BUS_RETURNED_FLAG_OUT <= 1'b0;
                            end else begin
                                state <= dta_pkg::ST_TX_IDLE;
                            end
                            te_next <= 1'b0;
                        end
                    end
                    dta_pkg::ST_TE_WAIT: begin
                        if (FORCE_CONTENTION_FLAG_IN) begin
                            FORCE_CONTENTION_OUT <= 1'b1;
                        end
                        if (ev_te) begin
                            te_seen <= 1'b1;
                        end
                        if (lp_expired) begin
                            state <= dta_pkg::ST_TX_IDLE;
                            BUS_RETURNED_FLAG_OUT <= 1'b1;
                        end else if (ev_bus_ret) begin
                            BUS_RETURNED_FLAG_OUT <= 1'b1;
                            if (!te_seen && REPEAT_TURNAROUND_FLAG_IN) begin
                                BTA_REQ_OUT <= 1'b1;
                                BUS_RETURNED_FLAG_OUT <= 1'b0;
                            end else begin
                                state <= dta_pkg::ST_TX_IDLE;
                            end
                        end
                    end
                    default: state <= dta_pkg::ST_TX_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            LINK_STATE_OUT <= 2'b00;
        end else begin
            LINK_STATE_OUT <= state;
        end
    end

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    logic lp_timeout, hs_timeout;
    logic [dta_pkg::CNT_W-1:0] hs_cnt;
    assign lp_expired = periph_owns && lp_cnt == LP_LIMIT;

    // Restarted by every bus return, so each repeated turnaround gets a full window
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lp_cnt <= 16'h0000;
            lp_timeout <= 1'b0;
        end else begin
            if (!periph_owns || ev_bus_ret) begin
                lp_cnt <= 16'h0000;
            end else if (lp_cnt != LP_LIMIT) begin
                lp_cnt <= lp_cnt + 16'h0001;
            end
            if (lp_expired) begin
                lp_timeout <= 1'b1;
            end else if (OP_START_IN) begin
                lp_timeout <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hs_cnt <= 16'h0000;
            hs_timeout <= 1'b0;
        end else begin
            if (!HS_ACTIVE_IN) begin
                hs_cnt <= 16'h0000;
            end else if (hs_cnt != HS_LIMIT) begin
                hs_cnt <= hs_cnt + 16'h0001;
            end
            if (HS_ACTIVE_IN && hs_cnt == HS_LIMIT) begin
                hs_timeout <= 1'b1;
            end else if (OP_START_IN) begin
                hs_timeout <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Acknowledge and read-back status
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ACK_RESPONSE_RECEIVED_OUT <= 1'b0;
            ACK_TRIGGER_NO_ERROR_OUT <= 1'b0;
            ACK_ERROR_REPORT_REG_OUT <= dta_pkg::ERR_REPORT_RST;
        end else if (ev_err) begin
            ACK_RESPONSE_RECEIVED_OUT <= 1'b1;
            ACK_TRIGGER_NO_ERROR_OUT <= 1'b0;
            // Bit order is kept as received; bit 14 is reserved and reads zero
            ACK_ERROR_REPORT_REG_OUT <= rx_cap.data & dta_pkg::ERR_VALID_MASK;
        end else if (ev_ack || ev_resp) begin
            ACK_RESPONSE_RECEIVED_OUT <= 1'b1;
            ACK_TRIGGER_NO_ERROR_OUT <= 1'b1;
            ACK_ERROR_REPORT_REG_OUT <= dta_pkg::ERR_REPORT_RST;
        end else if (OP_START_IN) begin
            ACK_RESPONSE_RECEIVED_OUT <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            READ_DATA_READY_OUT <= 1'b0;
        end else if (ev_resp) begin
            READ_DATA_READY_OUT <= 1'b1;
        end else if (READ_ALL_DONE_IN || OP_START_IN) begin
            READ_DATA_READY_OUT <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Tearing effect flag and frame sync pulse
    // ------------------------------------------------------------
    logic [dta_pkg::CNT_W-1:0] fs_cnt;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            TEARING_EVENT_FLAG_OUT <= 1'b0;
            FRAME_SYNC_OUT <= 1'b0;
            fs_cnt <= 16'h0000;
        end else begin
            if (ev_te) begin
                TEARING_EVENT_FLAG_OUT <= 1'b1;
            end else if (TEARING_CLEAR_IN) begin
                TEARING_EVENT_FLAG_OUT <= 1'b0;
            end
            if (ev_te) begin
                FRAME_SYNC_OUT <= 1'b1;
                fs_cnt <= 16'h0000;
            end else if (FRAME_SYNC_OUT) begin
                if (fs_cnt >= TEARING_PULSE_LENGTH_IN) begin
                    FRAME_SYNC_OUT <= 1'b0;
                end else begin
                    fs_cnt <= fs_cnt + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt sources, enables and output
    // ------------------------------------------------------------
    logic [dta_pkg::IRQ_W-1:0] next_status;

    always_comb begin
        next_status = '0;
        next_status[dta_pkg::IRQ_READ_READY] = READ_DATA_READY_OUT;
        next_status[dta_pkg::IRQ_BUS_RETURNED] = BUS_RETURNED_FLAG_OUT;
        next_status[dta_pkg::IRQ_ACK_RESP] = ACK_RESPONSE_RECEIVED_OUT;
        next_status[dta_pkg::IRQ_PLL_LOCK] = pll_s2;
        next_status[dta_pkg::IRQ_LP_TIMEOUT] = lp_timeout;
        next_status[dta_pkg::IRQ_HS_TIMEOUT] = hs_timeout;
        next_status[dta_pkg::IRQ_PKT_ACCEPT] = next_pkt_len(TOTAL_PAYLOAD_COUNT_IN,
            PARTITION_SIZE_IN, DCS_SEL_IN) <= BUF_FREE_IN;
        next_status[dta_pkg::IRQ_BUF_BASE +: dta_pkg::BUF_FLAG_N] = BUF_FLAGS_IN;
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_ENABLE_REG_OUT <= dta_pkg::IRQ_ENABLE_RST;
        end else if (IRQ_ENABLE_WR_IN) begin
            IRQ_ENABLE_REG_OUT <= IRQ_ENABLE_IN;
        end
    end

    // Two register stages give the latency that the host covers with one read
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_STATUS_REG_OUT <= '0;
            INT_N_OUT <= 1'b1;
        end else begin
            IRQ_STATUS_REG_OUT <= next_status;
            INT_N_OUT <= ~|(IRQ_STATUS_REG_OUT & IRQ_ENABLE_REG_OUT);
        end
    end

endmodule // dta_top

// >>> dv/dta_periph_model.sv
// Behavioural peripheral that sends link events towards the block
`timescale 1ns/1ps
module dta_periph_model (
    // Link pins towards the block
    output logic link_clk_out,
    output logic [2:0] evt_out,
    output logic [15:0] data_out
);
    initial begin
        link_clk_out = 1'b0;
        evt_out = 3'h0;
        data_out = 16'h0000;
    end
    // One event per 480 ns link period; the clock stands still outside it
    task automatic send(input dta_pkg::dta_rx_t m);
        evt_out = m.evt;
        data_out = m.data;
        #160;
        link_clk_out = 1'b1;
        #160;
        link_clk_out = 1'b0;
        #80;
        // Released lines turn over, so a stale value is never mistaken for data
        evt_out = ~m.evt;
        data_out = ~m.data;
        // Gap keeps a back-to-back call from driving the lines twice in one step
        #80;
    endtask
endmodule // dta_periph_model

// >>> dv/dta_monitor.sv
// Checker of turnaround, tearing and interrupt timing at the block's ports
`timescale 1ns/1ps
module dta_monitor (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Watched ports
    input wire logic PKT_SENT_IN,
    input wire logic PKT_IS_READ_IN,
    input wire logic BTA_AFTER_WRITE_FLAG_IN,
    input wire logic [15:0] TEARING_PULSE_LENGTH_IN,
    input wire logic BTA_REQ_OUT,
    input wire logic [1:0] LINK_STATE_OUT,
    input wire logic FRAME_SYNC_OUT,
    input wire logic BUS_RETURNED_FLAG_OUT,
    input wire logic ACK_TRIGGER_NO_ERROR_OUT,
    input wire logic [15:0] ACK_ERROR_REPORT_REG_OUT,
    input wire logic TEARING_EVENT_FLAG_OUT,
    input wire logic READ_DATA_READY_OUT,
    input wire logic [15:0] IRQ_STATUS_REG_OUT,
    input wire logic [15:0] IRQ_ENABLE_REG_OUT,
    input wire logic INT_N_OUT
);
    logic [16:0] high_cnt;
    logic pend;
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            high_cnt <= '0;
            pend <= 1'b0;
        end else begin
            high_cnt <= FRAME_SYNC_OUT ? high_cnt + 17'h0_0001 : '0;
            pend <= |(IRQ_STATUS_REG_OUT & IRQ_ENABLE_REG_OUT);
        end
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_send;
        PKT_SENT_IN && LINK_STATE_OUT == 2'h0 && (PKT_IS_READ_IN || BTA_AFTER_WRITE_FLAG_IN);
    endsequence
    sequence s_hand;
        BTA_REQ_OUT && !BUS_RETURNED_FLAG_OUT ##1 !BTA_REQ_OUT;
    endsequence
    bta_issue_a: assert property (s_send |-> ##2 s_hand)
        else $error("turnaround missing after packet");
    int_level_a: assert property (INT_N_OUT == !pend)
        else $error("interrupt level wrong");
    rsvd_bit_a: assert property (!ACK_ERROR_REPORT_REG_OUT[14])
        else $error("reserved report bit set");
    clean_ack_a: assert property (ACK_TRIGGER_NO_ERROR_OUT |-> ACK_ERROR_REPORT_REG_OUT == 16'h0000)
        else $error("report not clear on clean ack");
    sync_len_a: assert property ($fell(FRAME_SYNC_OUT) |-> high_cnt == {1'b0, TEARING_PULSE_LENGTH_IN} + 17'h0_0001)
        else $error("frame sync length wrong");
    tear_flag_a: assert property ($rose(FRAME_SYNC_OUT) |-> TEARING_EVENT_FLAG_OUT)
        else $error("tearing flag missing");
    reset_state_a: assert property ($fell(RST_IN) |-> IRQ_ENABLE_REG_OUT == 16'h0008 && BUS_RETURNED_FLAG_OUT)
        else $error("reset state wrong");
    status_copy_a: assert property (!$past(RST_IN) |-> IRQ_STATUS_REG_OUT[1:0] == {$past(BUS_RETURNED_FLAG_OUT), $past(READ_DATA_READY_OUT)})
        else $error("status bits wrong");
endmodule // dta_monitor
bind dta_top dta_monitor mon (.CLK_IN, .RST_IN, .PKT_SENT_IN, .PKT_IS_READ_IN,
    .BTA_AFTER_WRITE_FLAG_IN, .TEARING_PULSE_LENGTH_IN, .BTA_REQ_OUT, .LINK_STATE_OUT,
    .FRAME_SYNC_OUT, .BUS_RETURNED_FLAG_OUT, .ACK_TRIGGER_NO_ERROR_OUT,
    .ACK_ERROR_REPORT_REG_OUT, .TEARING_EVENT_FLAG_OUT, .READ_DATA_READY_OUT,
    .IRQ_STATUS_REG_OUT, .IRQ_ENABLE_REG_OUT, .INT_N_OUT);

// >>> dv/tb_top.sv
// Self-checking bench of the turnaround, tearing and interrupt block
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {dta_pkg::dta_rx_t rx; logic [15:0] rep; logic ok;} dta_row_t;
    logic CLK_IN = 1'b0, RST_IN = 1'b1, PLL_LOCK_IN = 1'b0, PKT_SENT_IN = 1'b0;
    logic PKT_IS_READ_IN = 1'b0, OP_START_IN = 1'b0, READ_ALL_DONE_IN = 1'b0;
    logic BTA_AFTER_WRITE_FLAG_IN = 1'b1, REPEAT_TURNAROUND_FLAG_IN = 1'b0;
    logic FORCE_CONTENTION_FLAG_IN = 1'b0, TEARING_CLEAR_IN = 1'b0, IRQ_ENABLE_WR_IN = 1'b0;
    logic [15:0] TEARING_PULSE_LENGTH_IN = 16'h0005, TOTAL_PAYLOAD_COUNT_IN = 16'h0004;
    logic [15:0] IRQ_ENABLE_IN = 16'h0000;
    logic HS_ACTIVE_IN = 1'b0;
    logic [5:0] BUF_FLAGS_IN = 6'h00;
    logic LINK_CLK_IN, BTA_REQ_OUT, FORCE_CONTENTION_OUT, LANE_LP11_OUT, FRAME_SYNC_OUT;
    logic BUS_RETURNED_FLAG_OUT, ACK_RESPONSE_RECEIVED_OUT, ACK_TRIGGER_NO_ERROR_OUT;
    logic TEARING_EVENT_FLAG_OUT, READ_DATA_READY_OUT, INT_N_OUT;
    logic [1:0] LINK_STATE_OUT;
    logic [2:0] RX_EVT_IN;
    logic [15:0] RX_DATA_IN, ACK_ERROR_REPORT_REG_OUT, IRQ_STATUS_REG_OUT, IRQ_ENABLE_REG_OUT;
    int bad_count = 0, tests_run = 0, cycles = 0;
    localparam dta_pkg::dta_rx_t ret_msg = '{dta_pkg::EVT_BUS_RETURN, 16'h0000};
    dta_row_t rows [4] = '{'{'{dta_pkg::EVT_ACK_TRIG, 16'h1234}, 16'h0000, 1'b1},
        '{'{dta_pkg::EVT_ERR_REPORT, 16'hFFFF}, 16'hBFFF, 1'b0},
        '{'{dta_pkg::EVT_ERR_REPORT, 16'h4001}, 16'h0001, 1'b0},
        '{'{dta_pkg::EVT_ERR_REPORT, 16'h8080}, 16'h8080, 1'b0}};
    dta_periph_model peer (.link_clk_out(LINK_CLK_IN), .evt_out(RX_EVT_IN), .data_out(RX_DATA_IN));
    // Short LP timer keeps the timeout case quick but above one link event
    dta_top #(.LP_RX_TIMEOUT(64), .HS_TX_TIMEOUT(16)) uut (.CLK_IN, .RST_IN, .LINK_CLK_IN,
        .RX_EVT_IN, .RX_DATA_IN, .PLL_LOCK_IN, .PKT_SENT_IN, .PKT_IS_READ_IN, .OP_START_IN,
        .READ_ALL_DONE_IN, .HS_ACTIVE_IN, .BUF_FLAGS_IN, .BUF_FREE_IN(16'h0010),
        .BTA_AFTER_WRITE_FLAG_IN, .REPEAT_TURNAROUND_FLAG_IN, .FORCE_CONTENTION_FLAG_IN,
        .TEARING_CLEAR_IN, .TEARING_PULSE_LENGTH_IN, .TOTAL_PAYLOAD_COUNT_IN,
        .PARTITION_SIZE_IN(16'h0000), .DCS_SEL_IN(1'b0), .IRQ_ENABLE_WR_IN, .IRQ_ENABLE_IN,
        .BTA_REQ_OUT, .FORCE_CONTENTION_OUT, .LANE_LP11_OUT, .LINK_STATE_OUT, .FRAME_SYNC_OUT,
        .BUS_RETURNED_FLAG_OUT, .ACK_RESPONSE_RECEIVED_OUT, .ACK_TRIGGER_NO_ERROR_OUT,
        .ACK_ERROR_REPORT_REG_OUT, .TEARING_EVENT_FLAG_OUT, .READ_DATA_READY_OUT,
        .IRQ_STATUS_REG_OUT, .IRQ_ENABLE_REG_OUT, .INT_N_OUT);
    always #20 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Checks land after the edge's updates, never in its time step
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_IN);
        #1;
    endtask
    task automatic send_pkt(input logic rd);
        @(posedge CLK_IN);
        OP_START_IN <= 1'b1;
        @(posedge CLK_IN);
        OP_START_IN <= 1'b0;
        PKT_IS_READ_IN <= rd;
        PKT_SENT_IN <= 1'b1;
        @(posedge CLK_IN);
        PKT_SENT_IN <= 1'b0;
        tick(6);
    endtask
    task automatic finish_test();
        $display("counts: %0d checks, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        tick(4);
        foreach (rows[k]) begin
            send_pkt(1'b0);
            chk(BUS_RETURNED_FLAG_OUT, 1'b0);
            peer.send(rows[k].rx);
            peer.send(ret_msg);
            tick(2);
            chk(BUS_RETURNED_FLAG_OUT, 1'b1);
            chk(ACK_RESPONSE_RECEIVED_OUT, 1'b1);
            chk(ACK_TRIGGER_NO_ERROR_OUT, rows[k].ok);
            chk(ACK_ERROR_REPORT_REG_OUT, rows[k].rep);
        end
        $display("test ack rows done");
        @(posedge CLK_IN);
        RST_IN <= 1'b1;
        tick(3);
        @(posedge CLK_IN);
        RST_IN <= 1'b0;
        tick(1);
        chk(BUS_RETURNED_FLAG_OUT, 1'b1);
        chk(IRQ_ENABLE_REG_OUT, 16'h0008);
        chk(INT_N_OUT, 1'b1);
        chk(LANE_LP11_OUT, 1'b1);
        @(posedge CLK_IN);
        PLL_LOCK_IN <= 1'b1;
        tick(8);
        chk(IRQ_STATUS_REG_OUT[3], 1'b1);
        chk(INT_N_OUT, 1'b0);
        @(posedge CLK_IN);
        IRQ_ENABLE_WR_IN <= 1'b1;
        IRQ_ENABLE_IN <= 16'h0040;
        @(posedge CLK_IN);
        IRQ_ENABLE_WR_IN <= 1'b0;
        tick(4);
        chk(IRQ_ENABLE_REG_OUT, 16'h0040);
        chk(INT_N_OUT, 1'b0);
        @(posedge CLK_IN);
        TOTAL_PAYLOAD_COUNT_IN <= 16'h0020;
        tick(4);
        chk(IRQ_STATUS_REG_OUT[6], 1'b0);
        chk(INT_N_OUT, 1'b1);
        chk(IRQ_STATUS_REG_OUT[5], 1'b0);
        @(posedge CLK_IN);
        HS_ACTIVE_IN <= 1'b1;
        BUF_FLAGS_IN <= 6'h2A;
        tick(20);
        chk(IRQ_STATUS_REG_OUT[5], 1'b1);
        chk(IRQ_STATUS_REG_OUT[12:7], 6'h2A);
        @(posedge CLK_IN);
        HS_ACTIVE_IN <= 1'b0;
        $display("test reset and interrupt done");
        @(posedge CLK_IN);
        BTA_AFTER_WRITE_FLAG_IN <= 1'b0;
        send_pkt(1'b1);
        chk(BUS_RETURNED_FLAG_OUT, 1'b0);
        @(posedge CLK_IN);
        FORCE_CONTENTION_FLAG_IN <= 1'b1;
        tick(3);
        chk(FORCE_CONTENTION_OUT, 1'b1);
        @(posedge CLK_IN);
        FORCE_CONTENTION_FLAG_IN <= 1'b0;
        peer.send('{dta_pkg::EVT_READ_RESP, 16'h00A5});
        peer.send(ret_msg);
        tick(2);
        chk(READ_DATA_READY_OUT, 1'b1);
        chk(ACK_TRIGGER_NO_ERROR_OUT, 1'b1);
        @(posedge CLK_IN);
        READ_ALL_DONE_IN <= 1'b1;
        @(posedge CLK_IN);
        READ_ALL_DONE_IN <= 1'b0;
        tick(3);
        chk(READ_DATA_READY_OUT, 1'b0);
        $display("test read done");
        @(posedge CLK_IN);
        BTA_AFTER_WRITE_FLAG_IN <= 1'b1;
        REPEAT_TURNAROUND_FLAG_IN <= 1'b1;
        send_pkt(1'b0);
        peer.send(ret_msg);
        tick(2);
        chk(LINK_STATE_OUT, 2'h3);
        chk(BUS_RETURNED_FLAG_OUT, 1'b0);
        peer.send(ret_msg);
        tick(2);
        chk(BUS_RETURNED_FLAG_OUT, 1'b0);
        peer.send('{dta_pkg::EVT_TE_TRIG, 16'h0000});
        tick(2);
        chk(TEARING_EVENT_FLAG_OUT, 1'b1);
        @(posedge CLK_IN);
        TEARING_CLEAR_IN <= 1'b1;
        @(posedge CLK_IN);
        TEARING_CLEAR_IN <= 1'b0;
        tick(3);
        chk(TEARING_EVENT_FLAG_OUT, 1'b0);
        peer.send('{dta_pkg::EVT_CONTENTION, 16'h0000});
        tick(2);
        chk(LANE_LP11_OUT, 1'b1);
        chk(LINK_STATE_OUT, 2'h0);
        send_pkt(1'b0);
        peer.send(ret_msg);
        tick(80);
        chk(IRQ_STATUS_REG_OUT[4], 1'b1);
        chk(BUS_RETURNED_FLAG_OUT, 1'b1);
        $display("test tearing and timeout done");
        finish_test();
    end
endmodule // tb_top
